// *** hdl/video_frontend_pkg.sv ***
// Constants for the display-input front-end control register bank
package video_frontend_pkg;

   // Register offsets; word index, byte address is four times the index
   localparam logic [7:0] sync_control_index  = 8'h10;
   localparam logic [7:0] clamp_coast_index   = 8'h11;
   localparam logic [7:0] precoast_index      = 8'h12;
   localparam logic [7:0] postcoast_index     = 8'h13;
   localparam logic [7:0] output_power_index  = 8'h14;
   localparam logic [7:0] sync_status_index   = 8'h15;
   localparam int         address_width       = 8;

   // Sync control (offset 0x10) fields used here
   localparam int vsync_override_bit = 1;
   localparam int vsync_select_bit   = 0;
   localparam logic [7:0] sync_control_reset = 8'h00;

   // Clamp and coast control fields
   localparam int clamp_disable_bit     = 7;
   localparam int red_clamp_bit         = 6;
   localparam int green_clamp_bit       = 5;
   localparam int blue_clamp_bit        = 4;
   localparam int coast_select_bit      = 3;
   localparam int coast_pol_override_bit = 2;
   localparam int coast_polarity_bit    = 1;
   localparam logic [7:0] clamp_coast_mask  = 8'hfe;
   localparam logic [7:0] clamp_coast_reset = 8'h0a;

   // Coast counts
   localparam logic [7:0] precoast_reset  = 8'h00;
   localparam logic [7:0] postcoast_reset = 8'h00;

   // Output and power control fields
   localparam int drive_high_bit     = 7;
   localparam int drive_low_bit      = 6;
   localparam int bandwidth_bit      = 5;
   localparam int clock_invert_bit   = 4;
   localparam int output_tristate_bit = 3;
   localparam int protect_addr_bit   = 2;
   localparam int chip_powerdown_bit = 1;
   localparam int output_mode_bit    = 0;
   localparam logic [7:0] output_power_reset = 8'hc2;

   // Sync activity status fields
   localparam int hsync_detect_bit = 7;
   localparam int sog_detect_bit   = 6;
   localparam int vsync_detect_bit = 5;

   // Drive strength encoding
   localparam logic [1:0] drive_low    = 2'h0;
   localparam logic [1:0] drive_medium = 2'h1;
   localparam logic [1:0] drive_high   = 2'h2;

   // Activity timeout, clock rate and bus answer
   localparam longint clock_hz          = 25000000;
   localparam longint activity_timeout_us = 200;
   localparam longint activity_timeout_cycles = activity_timeout_us * clock_hz / 1000000;
   localparam logic [31:0] unmapped_read_value = 32'h00000000;

endpackage : video_frontend_pkg

// *** hdl/video_frontend_control_regs.sv ***
// Control and status register bank of a display-input front end on Avalon-MM
//
// Summary of operation
// - Clamp bit 0 runs clamp timing, 1 disables
// - Clamp pulse timed from hsync trailing edge
// - Per-channel clamp select: ground or midscale
// - Coast select: 0 off, 1 internal coast
// - Coast vsync from pin or sync separator
// - Polarity override acts only with coast disabled
// - Coast polarity honoured only under user override
// - Precoast count of edges before vsync
// - Postcoast count extends coast after vsync
// - Drive field: 1x high, 01 medium, 00 low
// - Bandwidth bit: 10 MHz or 300 MHz
// - Clock invert acts only on digital interface
// - Output power-down three-states data and syncs
// - Config bit gives protection port address bit
// - Power-down bit: 0 down, 1 normal
// - Output mode bit: 4:4:4 or 4:2:2
// - 4:2:2: green luma, red chroma, blue off
// - Hsync detect shows edges on hsync input
// - Vsync override forces source to select bit
// - Vsync select: pin 0, separator 1
// - Analog activity is OR of three detects
//
// The Avalon-MM interface to the registers is this design's own decision.
module video_frontend_control_regs
   import video_frontend_pkg::*;
#(
   parameter int activity_timeout = int'(video_frontend_pkg::activity_timeout_cycles),
   parameter int timeout_width    = 16
)
(
   input  wire logic                                   clk,
   input  wire logic                                   rst_b,
   input  wire logic                                   clk_en,
   input  wire logic [video_frontend_pkg::address_width-1:0] address,
   input  wire logic                                   read,
   input  wire logic                                   write,
   input  wire logic [31:0]                            writedata,
   input  wire logic [3:0]                             byteenable,
   output logic      [31:0]                            readdata,
   output logic                                        waitrequest,
   input  wire logic                                   hsync_input,
   input  wire logic                                   vsync_input,
   input  wire logic                                   sync_on_green_input,
   input  wire logic                                   digital_interface,
   output logic                                        clamp_enable,
   output logic      [2:0]                             clamp_midscale,
   output logic                                        coast_enable,
   output logic                                        active_vsync_source,
   output logic                                        coast_user_polarity,
   output logic                                        coast_polarity,
   output logic      [7:0]                             precoast,
   output logic      [7:0]                             postcoast,
   output logic      [1:0]                             drive_strength,
   output logic                                        wide_bandwidth,
   output logic                                        data_clock_invert,
   output logic                                        output_tristate,
   output logic                                        protect_address_bit,
   output logic                                        chip_powerdown_n,
   output logic                                        output_mode_422,
   output logic                                        hsync_detect,
   output logic                                        analog_active
);
   import video_frontend_pkg::*;

   // Elaboration check on the timeout counter
   if (activity_timeout < 1 || activity_timeout >= (1 << timeout_width))
      $error("activity_timeout does not fit timeout_width");

   logic [7:0] sync_control;
   logic [7:0] clamp_coast_control;
   logic [7:0] precoast_count;
   logic [7:0] postcoast_count;
   logic [7:0] output_and_power_control;
   logic [7:0] sync_activity_status;
   logic       pending;
   logic [timeout_width-1:0] hsync_idle;
   logic [timeout_width-1:0] vsync_idle;
   logic [timeout_width-1:0] sog_idle;
   logic       hsync_last;
   logic       vsync_last;
   logic       sog_last;
   logic       hsync_seen;
   logic       vsync_seen;
   logic       sog_seen;
   logic       sync_primed;
   logic [7:0] next_readdata;

   // Decode of drive field into strength code
   function automatic logic [1:0] drive_decode(input logic [1:0] field);
      if (field[1])
      begin
         drive_decode = drive_high;
      end
      else if (field[0])
      begin
         drive_decode = drive_medium;
      end
      else
      begin
         drive_decode = drive_low;
      end
   endfunction

   // Merge a write byte with its lane enable
   function automatic logic [7:0] merge_byte(input logic [7:0] old_value, input logic [31:0] data,
                                             input logic [3:0] lanes, input logic [7:0] mask);
      if (lanes[0])
      begin
         merge_byte = data[7:0] & mask;
      end
      else
      begin
         merge_byte = old_value;
      end
   endfunction

   // Idle counter step: restart on edge, saturate at timeout
   function automatic logic [timeout_width-1:0] idle_step(input logic [timeout_width-1:0] count,
                                                         input logic edge_seen);
      if (edge_seen)
      begin
         idle_step = '0;
      end
      else if (count < timeout_width'(activity_timeout))
      begin
         idle_step = count + timeout_width'(1);
      end
      else
      begin
         idle_step = count;
      end
   endfunction

   // Bus handshake: one wait cycle per access, then accept
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pending     <= 1'b0;
         waitrequest <= 1'b1;
      end
      else if (clk_en)
      begin
         if ((read || write) && !pending && waitrequest)
         begin
            pending     <= 1'b1;
            waitrequest <= 1'b0;
         end
         else
         begin
            pending     <= 1'b0;
            waitrequest <= 1'b1;
         end
      end
   end

   // Register writes on the accepting edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_control             <= sync_control_reset;
         clamp_coast_control      <= clamp_coast_reset;
         precoast_count           <= precoast_reset;
         postcoast_count          <= postcoast_reset;
         output_and_power_control <= output_power_reset;
      end
      else if (clk_en && write && pending)
      begin
         unique case (address)
            sync_control_index:
               sync_control <= merge_byte(sync_control, writedata, byteenable, 8'hff);
            clamp_coast_index:
               clamp_coast_control <= merge_byte(clamp_coast_control, writedata, byteenable,
                                                 clamp_coast_mask);
            precoast_index:
               precoast_count <= merge_byte(precoast_count, writedata, byteenable, 8'hff);
            postcoast_index:
               postcoast_count <= merge_byte(postcoast_count, writedata, byteenable, 8'hff);
            output_power_index:
               output_and_power_control <= merge_byte(output_and_power_control, writedata,
                                                      byteenable, 8'hff);
            default:
               ;
         endcase
      end
   end

   // Read data mux; status and unmapped read as zero above the byte
   always_comb
   begin
      next_readdata = 8'h00;
      unique case (address)
         sync_control_index: next_readdata = sync_control;
         clamp_coast_index:  next_readdata = clamp_coast_control;
         precoast_index:     next_readdata = precoast_count;
         postcoast_index:    next_readdata = postcoast_count;
         output_power_index: next_readdata = output_and_power_control;
         sync_status_index:  next_readdata = sync_activity_status;
         default:            next_readdata = 8'h00;
      endcase
   end

   // Read data register, stands with waitrequest low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         readdata <= unmapped_read_value;
      end
      else if (clk_en && read && !pending && waitrequest)
      begin
         readdata <= {24'h000000, next_readdata};
      end
   end

   // Edge detection on the sync inputs; the first enabled cycle after reset only loads
   // the history, so a pin idling high gives no false edge
   assign hsync_seen = sync_primed && (hsync_input != hsync_last);
   assign vsync_seen = sync_primed && (vsync_input != vsync_last);
   assign sog_seen   = sync_primed && (sync_on_green_input != sog_last);

   // Activity watchdogs; a steady level ages out to no activity
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_primed <= 1'b0;
         hsync_last <= 1'b0;
         vsync_last <= 1'b0;
         sog_last   <= 1'b0;
         hsync_idle <= timeout_width'(activity_timeout);
         vsync_idle <= timeout_width'(activity_timeout);
         sog_idle   <= timeout_width'(activity_timeout);
      end
      else if (clk_en)
      begin
         sync_primed <= 1'b1;
         hsync_last <= hsync_input;
         vsync_last <= vsync_input;
         sog_last   <= sync_on_green_input;
         hsync_idle <= idle_step(hsync_idle, hsync_seen);
         vsync_idle <= idle_step(vsync_idle, vsync_seen);
         sog_idle   <= idle_step(sog_idle, sog_seen);
      end
   end

   // Status register: detect bits set by edges, cleared by timeout
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_activity_status <= 8'h00;
      end
      else if (clk_en)
      begin
         sync_activity_status <= 8'h00;
         sync_activity_status[hsync_detect_bit] <= hsync_seen ||
            (hsync_idle < timeout_width'(activity_timeout) - timeout_width'(1));
         sync_activity_status[sog_detect_bit]   <= sog_seen ||
            (sog_idle < timeout_width'(activity_timeout) - timeout_width'(1));
         sync_activity_status[vsync_detect_bit] <= vsync_seen ||
            (vsync_idle < timeout_width'(activity_timeout) - timeout_width'(1));
      end
   end

   // Registered controls toward the analog and output sections
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         clamp_enable        <= 1'b0;
         clamp_midscale      <= 3'h0;
         coast_enable        <= 1'b0;
         active_vsync_source <= 1'b0;
         coast_user_polarity <= 1'b0;
         coast_polarity      <= 1'b0;
         precoast            <= 8'h00;
         postcoast           <= 8'h00;
         drive_strength      <= drive_low;
         wide_bandwidth      <= 1'b0;
         data_clock_invert   <= 1'b0;
         output_tristate     <= 1'b0;
         protect_address_bit <= 1'b0;
         chip_powerdown_n    <= 1'b0;
         output_mode_422     <= 1'b0;
         hsync_detect        <= 1'b0;
         analog_active       <= 1'b0;
      end
      else if (clk_en)
      begin
         // Clamp pulse itself is timed from hsync trailing edge downstream
         clamp_enable   <= !clamp_coast_control[clamp_disable_bit];
         clamp_midscale <= {clamp_coast_control[red_clamp_bit],
                            clamp_coast_control[green_clamp_bit],
                            clamp_coast_control[blue_clamp_bit]};
         coast_enable   <= clamp_coast_control[coast_select_bit];
         // Forced source when overridden, else follow vsync activity
         if (sync_control[vsync_override_bit])
         begin
            active_vsync_source <= sync_control[vsync_select_bit];
         end
         else
         begin
            active_vsync_source <= sync_activity_status[vsync_detect_bit];
         end
         // User polarity only with coast off and override set
         coast_user_polarity <= !clamp_coast_control[coast_select_bit] &&
                                clamp_coast_control[coast_pol_override_bit];
         coast_polarity      <= clamp_coast_control[coast_polarity_bit];
         precoast            <= precoast_count;
         postcoast           <= postcoast_count;
         drive_strength      <= drive_decode(output_and_power_control[drive_high_bit:drive_low_bit]);
         wide_bandwidth      <= output_and_power_control[bandwidth_bit];
         data_clock_invert   <= output_and_power_control[clock_invert_bit] && digital_interface;
         output_tristate     <= output_and_power_control[output_tristate_bit];
         protect_address_bit <= output_and_power_control[protect_addr_bit];
         chip_powerdown_n    <= output_and_power_control[chip_powerdown_bit];
         output_mode_422     <= output_and_power_control[output_mode_bit];
         hsync_detect        <= sync_activity_status[hsync_detect_bit];
         analog_active       <= sync_activity_status[hsync_detect_bit] ||
                                sync_activity_status[sog_detect_bit] ||
                                sync_activity_status[vsync_detect_bit];
      end
   end

endmodule // video_frontend_control_regs

// *** sim/video_frontend_control_regs_asserts.sv ***
// Port-level assertion checker for the front-end control register bank
module video_frontend_control_regs_asserts
#(
   parameter int activity_timeout = 8
)
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        clk_en,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        hsync_input,
   input wire logic        digital_interface,
   input wire logic        coast_enable,
   input wire logic        coast_user_polarity,
   input wire logic [1:0]  drive_strength,
   input wire logic        data_clock_invert,
   input wire logic        hsync_detect,
   input wire logic        analog_active
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic last_hs;
   int   idle_cycles;

   // Counts enabled cycles since the hsync input last changed
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         last_hs     <= 1'b0;
         idle_cycles <= 0;
      end
      else
      begin
         last_hs <= hsync_input;
         if (clk_en)
            idle_cycles <= (hsync_input != last_hs) ? 0 : idle_cycles + 1;
      end
   end

   a_wait_answer: assert property (clk_en && (read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_pulse: assert property (clk_en && !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_read_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_user_pol_gated: assert property (coast_user_polarity |-> !coast_enable)
      else $error("user coast polarity active with internal coast");
   a_drive_code_legal: assert property (drive_strength != 2'h3)
      else $error("drive strength code out of range");
   a_clk_inv_digital: assert property (clk_en && !digital_interface |=> !data_clock_invert)
      else $error("clock invert active without digital interface");
   a_analog_or: assert property (hsync_detect |-> analog_active)
      else $error("hsync activity not seen in analog activity");
   a_hsync_edge_sets: assert property (clk_en && $changed(hsync_input) |-> ##[1:2] hsync_detect)
      else $error("hsync edge not reported");
   a_hsync_idle_clears: assert property (idle_cycles > activity_timeout + 3 |-> !hsync_detect)
      else $error("hsync detect held without edges");

   cover property (write && !waitrequest);
   cover property (read && !waitrequest);
   cover property ($fell(hsync_detect));
endmodule // video_frontend_control_regs_asserts

bind video_frontend_control_regs video_frontend_control_regs_asserts #(.activity_timeout(activity_timeout)) chk (
   .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .hsync_input(hsync_input), .digital_interface(digital_interface),
   .coast_enable(coast_enable), .coast_user_polarity(coast_user_polarity), .drive_strength(drive_strength),
   .data_clock_invert(data_clock_invert), .hsync_detect(hsync_detect), .analog_active(analog_active));

// *** sim/video_frontend_control_regs_tb.sv ***
// Self-checking bench for the front-end control register bank
module video_frontend_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import video_frontend_pkg::*;

   localparam int tmo = 8;
   logic        clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
   logic        hsync_input = 1'b0, vsync_input = 1'b0, sync_on_green_input = 1'b0, digital_interface = 1'b0;
   logic [2:0]  sync_run = 3'b000;
   logic [7:0]  address = 8'h00;
   logic [31:0] writedata = 32'h00000000, readdata, q;
   logic [3:0]  byteenable = 4'hf;
   logic        clamp_enable, coast_enable, active_vsync_source, coast_user_polarity, coast_polarity;
   logic        wide_bandwidth, data_clock_invert, output_tristate, protect_address_bit, chip_powerdown_n;
   logic        output_mode_422, hsync_detect, analog_active;
   logic [2:0]  clamp_midscale;
   logic [7:0]  precoast, postcoast;
   logic [1:0]  drive_strength;
   int          mismatches = 0, n_checks = 0;
   logic [7:0]  cc_vals [4] = '{8'h06, 8'hf0, 8'h81, 8'hff};
   logic [7:0]  op_vals [4] = '{8'h40, 8'h00, 8'h80, 8'h3d};

   video_frontend_control_regs #(.activity_timeout(tmo), .timeout_width(16)) dut (
      .clk, .rst_b, .clk_en, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
      .hsync_input, .vsync_input, .sync_on_green_input, .digital_interface, .clamp_enable, .clamp_midscale,
      .coast_enable, .active_vsync_source, .coast_user_polarity, .coast_polarity, .precoast, .postcoast,
      .drive_strength, .wide_bandwidth, .data_clock_invert, .output_tristate, .protect_address_bit,
      .chip_powerdown_n, .output_mode_422, .hsync_detect, .analog_active);

   // Clock and free-running sync activity, one enable bit per sync input
   always #20 clk = ~clk;
   always @(posedge clk)
      {hsync_input, sync_on_green_input, vsync_input} <= {hsync_input, sync_on_green_input, vsync_input} ^ sync_run;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge clk);
      address <= a;
      writedata <= {24'h000000, d};
      byteenable <= be;
      write <= wr;
      read <= !wr;
      // Only the watchdog ends a wait that never gets an answer
      do
      begin
         @(posedge clk);
      end
      while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hf);
      check(q, {24'h000000, exp});
   endtask

   // Expected control outputs from register contents
   function automatic logic [14:0] exp_outs(input logic [7:0] cc, input logic [7:0] op, input logic dig);
      return {~cc[7], cc[6:4], cc[3], ~cc[3] & cc[2], cc[1], op[7] ? 2'h2 : {1'b0, op[6]}, op[5], op[4] & dig,
              op[3:0]};
   endfunction

   task automatic cmp_outs(input logic [7:0] cc, input logic [7:0] op);
      check({17'h00000, clamp_enable, clamp_midscale, coast_enable, coast_user_polarity, coast_polarity,
             drive_strength, wide_bandwidth, data_clock_invert, output_tristate, protect_address_bit,
             chip_powerdown_n, output_mode_422}, {17'h00000, exp_outs(cc, op, digital_interface)});
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(sync_control_index, sync_control_reset);
      rd(clamp_coast_index, clamp_coast_reset);
      rd(precoast_index, precoast_reset);
      rd(postcoast_index, postcoast_reset);
      rd(output_power_index, output_power_reset);
      rd(sync_status_index, 8'h00);
      cmp_outs(clamp_coast_reset, output_power_reset);
      for (int i = 0; i < 4; i++)
      begin
         digital_interface <= i[0];
         wr(clamp_coast_index, cc_vals[i]);
         wr(output_power_index, op_vals[i]);
         repeat (2) @(posedge clk);
         cmp_outs(cc_vals[i], op_vals[i]);
         rd(clamp_coast_index, cc_vals[i] & clamp_coast_mask);
         rd(output_power_index, op_vals[i]);
      end
      // Clock enable low freezes the outputs although an input moves
      clk_en <= 1'b0;
      digital_interface <= 1'b0;
      repeat (3) @(posedge clk);
      check({31'h0, data_clock_invert}, 32'h1);
      clk_en <= 1'b1;
      repeat (2) @(posedge clk);
      check({31'h0, data_clock_invert}, 32'h0);
      wr(precoast_index, 8'hff);
      wr(postcoast_index, 8'h01);
      bus(1'b1, precoast_index, 8'h00, 4'h0);
      rd(precoast_index, 8'hff);
      rd(postcoast_index, 8'h01);
      check({16'h0000, precoast, postcoast}, 32'h0000ff01);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      wr(sync_status_index, 8'hff);
      rd(sync_status_index, 8'h00);
      wr(sync_control_index, 8'h03);
      repeat (2) @(posedge clk);
      check({31'h0, active_vsync_source}, 32'h1);
      wr(sync_control_index, 8'h02);
      repeat (2) @(posedge clk);
      check({31'h0, active_vsync_source}, 32'h0);
      rd(sync_control_index, 8'h02);
      sync_run <= 3'b100;
      repeat (6) @(posedge clk);
      check({30'h0, hsync_detect, analog_active}, 32'h3);
      rd(sync_status_index, 8'h80);
      sync_run <= 3'b000;
      repeat (tmo + 6) @(posedge clk);
      check({30'h0, hsync_detect, analog_active}, 32'h0);
      rd(sync_status_index, 8'h00);
      // Automatic vsync source follows vsync activity; other detects feed analog activity
      wr(sync_control_index, 8'h00);
      sync_run <= 3'b011;
      repeat (6) @(posedge clk);
      check({29'h0, hsync_detect, analog_active, active_vsync_source}, 32'h3);
      rd(sync_status_index, 8'h60);
      sync_run <= 3'b000;
      repeat (tmo + 6) @(posedge clk);
      check({29'h0, hsync_detect, analog_active, active_vsync_source}, 32'h0);
      print_verdict();
   end
endmodule // video_frontend_control_regs_tb
